//--- src/ccs_encoder.sv
// Charger sequencing, timers and open-drain status pin encoder
`timescale 1ns/1ps
module ccs_encoder #(
  parameter int unsigned TRICKLE_TICKS = ccs_pkg::TRICKLE_TICKS,
  parameter int unsigned SAFETY_TICKS = ccs_pkg::SAFETY_TICKS,
  parameter int unsigned TICK_CYC = ccs_pkg::TICK_CYC,
  parameter int unsigned RECHG_FILT_CYC = ccs_pkg::RECHG_FILT_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire ccs_pkg::ccs_sense_s sense_in,
  input wire logic charger_reset,
  output logic charge_enable,
  output logic trickle_current,
  output logic switcher_enable,
  output logic suspend_reg_enable,
  output logic charge_status_pin_o,
  output logic charge_status_pin_oe_n
);
  ccs_pkg::ccs_sync_s sy_q;
  ccs_pkg::ccs_sync_s sy_d;
  ccs_pkg::ccs_state_s s_q;
  ccs_pkg::ccs_state_s s_d;
  ccs_pkg::ccs_sense_s sn;
  logic therm_pause;
  logic bad_fault;
  logic temp_fault;
  logic tick;
  logic rech_ok;
  logic uvlo_now;
  logic [4:0] duty;
  logic [15:0] half_len;
  logic [11:0] duty_cyc;

  // Sensing comes from analog comparators, so every bit is synchronised
  always_comb begin
    sy_d = sy_q;
    sy_d.meas1 = sense_in;
    sy_d.meas2 = sy_q.meas1;
    sy_d.sync1 = {charger_reset, 1'b0};
    sy_d.sync2 = sy_q.sync1;
  end
  assign sn = ccs_pkg::ccs_sense_s'(sy_q.meas2);

  assign therm_pause = !sn.therm_grounded && (sn.therm_hot || sn.therm_cold);
  assign tick = (s_q.tick_cnt == 17'(TICK_CYC - 1));
  assign rech_ok = (s_q.rech_cnt >= 18'(RECHG_FILT_CYC));
  assign bad_fault = (s_q.state == ccs_pkg::CCS_BAD);
  assign temp_fault = therm_pause && (s_q.state inside {ccs_pkg::CCS_TRICKLE, ccs_pkg::CCS_CC, ccs_pkg::CCS_FLOAT});
  // Lockout hysteresis: on above the on threshold, off below the off one, else hold
  assign uvlo_now = sn.bus_above_on ? 1'b1 : (sn.bus_below_off ? 1'b0 : s_q.uvlo_ok);

  always_comb begin
    // Bad battery wins over temperature
    if (bad_fault) begin
      half_len = 16'(ccs_pkg::BAD_HALF_CAR);
      duty = s_q.blink_hi ? ccs_pkg::BAD_DUTY_HI : ccs_pkg::BAD_DUTY_LO;
    end else begin
      half_len = 16'(ccs_pkg::TEMP_HALF_CAR);
      duty = s_q.blink_hi ? ccs_pkg::TEMP_DUTY_HI : ccs_pkg::TEMP_DUTY_LO;
    end
    duty_cyc = 12'((ccs_pkg::CARRIER_CYC * duty) / ccs_pkg::DUTY_FULL);
  end

  always_comb begin
    s_d = s_q;
    s_d.uvlo_ok = uvlo_now;
    s_d.sw_on = uvlo_now && !sn.usb_suspend;
    s_d.tick_cnt = tick ? 17'h0_0000 : s_q.tick_cnt + 17'h0_0001;
    if (!sn.bat_below_recharge) begin
      s_d.rech_cnt = 18'h0_0000;
    end else if (!rech_ok) begin
      s_d.rech_cnt = s_q.rech_cnt + 18'h0_0001;
    end
    // Carrier and blink dividers run always so pattern phase stays smooth
    if (s_q.car_cnt == 12'(ccs_pkg::CARRIER_CYC - 1)) begin
      s_d.car_cnt = 12'h000;
      if (s_q.blink_cnt >= half_len - 16'h0001) begin
        s_d.blink_cnt = 16'h0000;
        s_d.blink_hi = !s_q.blink_hi;
      end else begin
        s_d.blink_cnt = s_q.blink_cnt + 16'h0001;
      end
    end else begin
      s_d.car_cnt = s_q.car_cnt + 12'h001;
    end
    case (s_q.state)
      ccs_pkg::CCS_IDLE: begin
        s_d.tmr_cnt = 24'h00_0000;
        if (uvlo_now) begin
          s_d.state = ccs_pkg::CCS_TRICKLE;
        end
      end
      ccs_pkg::CCS_TRICKLE: begin
        if (!sn.bat_below_trickle) begin
          s_d.state = ccs_pkg::CCS_CC;
          s_d.tmr_cnt = 24'h00_0000;
        end else if (s_q.tmr_cnt >= 24'(TRICKLE_TICKS)) begin
          s_d.state = ccs_pkg::CCS_BAD;
        end else if (tick && !therm_pause) begin
          s_d.tmr_cnt = s_q.tmr_cnt + 24'h00_0001;
        end
      end
      ccs_pkg::CCS_CC: begin
        if (sn.bat_at_float) begin
          s_d.state = ccs_pkg::CCS_FLOAT;
          s_d.tmr_cnt = 24'h00_0000;
          s_d.end_seen = 1'b0;
        end
      end
      ccs_pkg::CCS_FLOAT: begin
        if (sn.current_below_tenth && !sn.input_current_limit) begin
          s_d.end_seen = 1'b1;
        end
        if (rech_ok) begin
          s_d.tmr_cnt = 24'h00_0000;
        end else if (s_q.tmr_cnt >= 24'(SAFETY_TICKS)) begin
          s_d.state = ccs_pkg::CCS_DONE;
        end else if (tick && !therm_pause) begin
          s_d.tmr_cnt = s_q.tmr_cnt + 24'h00_0001;
        end
      end
      ccs_pkg::CCS_DONE: begin
        if (rech_ok) begin
          s_d.state = ccs_pkg::CCS_TRICKLE;
          s_d.tmr_cnt = 24'h00_0000;
          // A recharge cycle is a fresh charge cycle, so the pin must go low again
          s_d.end_seen = 1'b0;
        end
      end
      ccs_pkg::CCS_BAD: begin
        s_d.tmr_cnt = 24'h00_0000;
      end
      default: begin
        s_d.state = ccs_pkg::CCS_IDLE;
      end
    endcase
    // Lockout or a host reset returns to idle; re-entry restarts cycle and timer
    if (!uvlo_now || sy_q.sync2[1]) begin
      s_d.state = ccs_pkg::CCS_IDLE;
      s_d.tmr_cnt = 24'h00_0000;
      s_d.end_seen = 1'b0;
    end
    // Pin: low while charging, released when done, carrier on faults
    if (bad_fault || temp_fault) begin
      s_d.pin_low = (s_d.car_cnt < duty_cyc);
    end else begin
      s_d.pin_low = (s_d.state inside {ccs_pkg::CCS_TRICKLE, ccs_pkg::CCS_CC, ccs_pkg::CCS_FLOAT}) &&
                    !s_d.end_seen;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sy_q <= '0;
      s_q <= '{state: ccs_pkg::CCS_IDLE, default: '0};
    end else begin
      sy_q <= sy_d;
      s_q <= s_d;
    end
  end

  assign charge_enable = (s_q.state inside {ccs_pkg::CCS_TRICKLE, ccs_pkg::CCS_CC, ccs_pkg::CCS_FLOAT}) &&
                         !therm_pause;
  assign trickle_current = (s_q.state == ccs_pkg::CCS_TRICKLE);
  assign switcher_enable = s_q.sw_on;
  assign suspend_reg_enable = !s_q.sw_on && sn.usb_suspend;
  assign charge_status_pin_o = 1'b0;
  assign charge_status_pin_oe_n = !s_q.pin_low;
endmodule

//--- src/ccs_pkg.sv
// Package with constants and types for the charger control and status encoder
// What this block does
// - Below trickle threshold at cycle start, charge current limited to one tenth
// - Below trickle threshold over half an hour: terminate, show unresponsive-battery fault
// - Above trickle threshold, switch to full constant-current charging
// - At float voltage start four-hour safety timer; stop charging on expiry
// - After safety-timer termination, restart cycle when battery falls below recharge threshold
// - Below-recharge must persist over 1.3ms before restart or timer reset
// - Supply lockout going low then high restarts charge cycle and safety timer
// - Switcher enabled only above lockout thresholds, disabled below them
// - Suspend disables switcher; suspend regulator active only while switcher off
// - Status pin low while charging, released once float and one-tenth current reached
// - One-tenth end-of-charge ignored while input is in current limit
// - Faults toggle status pin at 35kHz with blink-modulated duty pair
// - Temperature fault: duty 6.25% and 93.75%, 1.5Hz blink, equal halves
// - Unresponsive fault: duty 12.5% and 87.5%, 6.1Hz blink, equal halves
// - Pause charging while thermistor reads hot or cold; resume in range
// - Temperature pause during float also freezes the safety timer
// - Thermistor input held at ground disables temperature pausing
package ccs_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned CARRIER_HZ = 35000;
  localparam int unsigned CARRIER_CYC = CLK_HZ / CARRIER_HZ;
  // Duty in sixteenths of a carrier period
  localparam logic [4:0] TEMP_DUTY_LO = 5'h01;
  localparam logic [4:0] TEMP_DUTY_HI = 5'h0f;
  localparam logic [4:0] BAD_DUTY_LO = 5'h02;
  localparam logic [4:0] BAD_DUTY_HI = 5'h0e;
  localparam logic [4:0] DUTY_FULL = 5'h10;
  // Blink rates in tenths of a hertz; half period in carrier periods
  localparam int unsigned TEMP_BLINK_DHZ = 15;
  localparam int unsigned BAD_BLINK_DHZ = 61;
  localparam int unsigned TEMP_HALF_CAR = (CARRIER_HZ * 10) / (2 * TEMP_BLINK_DHZ);
  localparam int unsigned BAD_HALF_CAR = (CARRIER_HZ * 10) / (2 * BAD_BLINK_DHZ);
  localparam int unsigned RECHG_FILT_US = 1300;
  localparam int unsigned RECHG_FILT_CYC = (RECHG_FILT_US * (CLK_HZ / 1000000)) + 1;
  localparam int unsigned TICK_HZ = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int unsigned TRICKLE_MIN = 30;
  localparam int unsigned SAFETY_MIN = 240;
  localparam int unsigned TRICKLE_TICKS = TRICKLE_MIN * 60 * TICK_HZ;
  localparam int unsigned SAFETY_TICKS = SAFETY_MIN * 60 * TICK_HZ;

  typedef enum logic [2:0] {
    CCS_IDLE = 3'h0,
    CCS_TRICKLE = 3'h1,
    CCS_CC = 3'h2,
    CCS_FLOAT = 3'h3,
    CCS_DONE = 3'h4,
    CCS_BAD = 3'h5
  } ccs_state_e;

  typedef struct packed {
    logic bat_below_trickle;
    logic bat_at_float;
    logic bat_below_recharge;
    logic current_below_tenth;
    logic input_current_limit;
    logic therm_hot;
    logic therm_cold;
    logic therm_grounded;
    logic bus_above_on;
    logic bus_below_off;
    logic usb_suspend;
  } ccs_sense_s;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [10:0] meas1;
    logic [10:0] meas2;
  } ccs_sync_s;

  typedef struct packed {
    ccs_state_e state;
    logic uvlo_ok;
    logic sw_on;
    logic end_seen;
    logic [17:0] rech_cnt;
    logic [16:0] tick_cnt;
    logic [23:0] tmr_cnt;
    logic [11:0] car_cnt;
    logic [15:0] blink_cnt;
    logic blink_hi;
    logic pin_low;
  } ccs_state_s;
endpackage

//--- tb/ccs_encoder_assertions.sv
// Port checker for the charger status encoder
`timescale 1ns/1ps
module ccs_encoder_assertions (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire ccs_pkg::ccs_sense_s sense_in,
  input wire logic charger_reset,
  input wire logic charge_enable,
  input wire logic trickle_current,
  input wire logic switcher_enable,
  input wire logic suspend_reg_enable,
  input wire logic charge_status_pin_o,
  input wire logic charge_status_pin_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Four cycles cover two sync flops plus the state register
  sequence s_off; sense_in.bus_below_off [*4]; endsequence
  sequence s_susp; sense_in.usb_suspend [*4]; endsequence
  sequence s_above; !sense_in.bat_below_trickle [*4]; endsequence
  chk_pin_data_zero: assert property (charge_status_pin_o == 1'b0) else $error("pin data high");
  chk_suspend_excl: assert property (suspend_reg_enable |-> !switcher_enable) else $error("both on");
  chk_suspend_on: assert property (s_susp |-> suspend_reg_enable && !switcher_enable) else $error("no sus");
  chk_bus_off: assert property (s_off |-> !switcher_enable) else $error("switcher on in lockout");
  chk_switch_cause: assert property ($rose(switcher_enable) |->
    $past(sense_in.bus_above_on, 3) || $past(sense_in.usb_suspend, 4))
    else $error("switcher on without supply");
  chk_trickle_leave: assert property (s_above ##0 trickle_current |=> !trickle_current)
    else $error("trickle kept");
  chk_hot_pause: assert property ((sense_in.therm_hot && !sense_in.therm_grounded) [*4] |-> !charge_enable)
    else $error("hot not paused");
  chk_cold_pause: assert property ((sense_in.therm_cold && !sense_in.therm_grounded) [*4] |-> !charge_enable)
    else $error("cold not paused");
  chk_reset_idle: assert property (charger_reset [*4] |-> !charge_enable && !trickle_current)
    else $error("reset ignored");
  chk_charging_low: assert property ((trickle_current && charge_enable) [*2] |-> !charge_status_pin_oe_n)
    else $error("pin released in trickle");
endmodule
bind ccs_encoder ccs_encoder_assertions i_chk (.ref_clk(ref_clk), .resetn(resetn), .sense_in(sense_in),
  .charger_reset(charger_reset), .charge_enable(charge_enable), .trickle_current(trickle_current),
  .switcher_enable(switcher_enable), .suspend_reg_enable(suspend_reg_enable),
  .charge_status_pin_o(charge_status_pin_o), .charge_status_pin_oe_n(charge_status_pin_oe_n));

//--- tb/ccs_status_host.sv
// Host model that times low runs of the pulled-up status line
`timescale 1ns/1ps
module ccs_status_host (
  input wire logic ref_clk,
  input wire logic pin_level,
  output logic run_valid,
  output logic [15:0] run_len
);
  logic [15:0] cnt_q;
  logic last_q;
  initial begin
    cnt_q = 16'h0000;
    last_q = 1'b1;
    run_valid = 1'b0;
    run_len = 16'h0000;
  end
  // A half-period run straddles a blink edge, so it is thrown away
  always @(posedge ref_clk) begin
    run_valid <= !last_q && pin_level && cnt_q != 16'h06f9;
    run_len <= cnt_q;
    cnt_q <= pin_level ? 16'h0000 : cnt_q + 16'h0001;
    last_q <= pin_level;
  end
endmodule

//--- tb/ccs_encoder_test.sv
// Self-checking bench for the charger status encoder
`timescale 1ns/1ps
module ccs_encoder_test;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic charger_reset = 1'b0;
  ccs_pkg::ccs_sense_s s = '0;
  logic ce, tc, swe, sre, po, poe_n, rv;
  logic [15:0] rl;
  logic [15:0] exp_q[$];
  logic [31:0] rnd = 32'h0827_ebed;
  int errors = 0;
  int n_compared = 0;
  wire logic pin_level = poe_n ? 1'b1 : po;
  always #4 ref_clk = ~ref_clk;
  ccs_encoder #(.TRICKLE_TICKS(20), .SAFETY_TICKS(50), .TICK_CYC(10), .RECHG_FILT_CYC(50)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .sense_in(s), .charger_reset(charger_reset), .charge_enable(ce),
    .trickle_current(tc), .switcher_enable(swe), .suspend_reg_enable(sre), .charge_status_pin_o(po),
    .charge_status_pin_oe_n(poe_n));
  ccs_status_host i_host (.ref_clk(ref_clk), .pin_level(pin_level), .run_valid(rv), .run_len(rl));
  task automatic step(int n);
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    repeat (n + int'(rnd[2:0])) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(logic [15:0] a, logic [15:0] e);
    n_compared++;
    if (a !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task close_out;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge ref_clk) if (rv === 1'b1 && exp_q.size() != 0) chk(rl, exp_q.pop_front());
  initial begin
    #400000;
    errors++;
    close_out;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 resetn = 1'b1;
    s.bat_below_trickle = 1'b1;
    s.bus_above_on = 1'b1;
    step(6);
    chk(tc, 1'b1);
    chk(poe_n, 1'b0);
    chk(swe, 1'b1);
    // Timeout is 20 ticks of 10 cycles; hot is then set, but only the bad-battery fault is raised
    step(260);
    s.therm_hot = 1'b1;
    chk(ce, 1'b0);
    step(3700);
    exp_q.push_back(16'(ccs_pkg::CARRIER_CYC * ccs_pkg::BAD_DUTY_LO / ccs_pkg::DUTY_FULL));
    step(3700);
    charger_reset = 1'b1;
    step(6);
    chk(ce, 1'b0);
    charger_reset = 1'b0;
    s.bat_below_trickle = 1'b0;
    s.therm_hot = 1'b0;
    s.current_below_tenth = rnd[0];
    step(8);
    chk(tc, 1'b0);
    chk(ce, 1'b1);
    chk(poe_n, 1'b0);
    s.therm_hot = 1'b1;
    step(3700);
    exp_q.push_back(16'(ccs_pkg::CARRIER_CYC * ccs_pkg::TEMP_DUTY_LO / ccs_pkg::DUTY_FULL));
    step(3700);
    s.therm_hot = 1'b0;
    s.therm_cold = 1'b1;
    step(6);
    chk(ce, 1'b0);
    s.therm_grounded = 1'b1;
    step(6);
    chk(ce, 1'b1);
    s.therm_cold = 1'b0;
    s.therm_grounded = 1'b0;
    s.bat_at_float = 1'b1;
    s.input_current_limit = 1'b1;
    s.current_below_tenth = 1'b1;
    step(6);
    chk(poe_n, 1'b0);
    s.input_current_limit = 1'b0;
    step(6);
    chk(poe_n, 1'b1);
    step(600);
    chk(ce, 1'b0);
    // A dip shorter than the filter must not restart
    s.bat_below_recharge = 1'b1;
    repeat (30) @(posedge ref_clk);
    #1 s.bat_below_recharge = 1'b0;
    step(6);
    chk(ce, 1'b0);
    s.current_below_tenth = 1'b0;
    s.bat_below_recharge = 1'b1;
    step(70);
    chk(ce, 1'b1);
    chk(poe_n, 1'b0);
    s.bat_below_recharge = 1'b0;
    s.bus_above_on = 1'b0;
    s.bus_below_off = 1'b1;
    step(6);
    chk(swe, 1'b0);
    chk(ce, 1'b0);
    s.bus_above_on = 1'b1;
    s.bus_below_off = 1'b0;
    step(8);
    chk(ce, 1'b1);
    s.usb_suspend = 1'b1;
    step(6);
    chk(swe, 1'b0);
    chk(sre, 1'b1);
    chk(16'(exp_q.size()), 16'h0000);
    close_out;
  end
endmodule
